// ===== losc_defs.vh
// constants for the loss-of-signal status combiner
`ifndef LOSC_DEFS_VH
`define LOSC_DEFS_VH
// enable vector bit positions
`define LOSC_EN_W 6
`define LOSC_EN_BASE 0
`define LOSC_EN_SYNC 1
`define LOSC_EN_PLL 2
`define LOSC_EN_DEC 3
`define LOSC_EN_GAIN 4
`define LOSC_EN_CAL 5
// reset value: every contribution disabled
`define LOSC_EN_RST 6'h00
// number of synchroniser stages for pin inputs
`define LOSC_SYNC_STAGES 3
`endif

// ===== losc_sync.v
// three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
`include "losc_defs.vh"
module losc_sync
(
    input wire mclk_i,
    input wire resetn_i,
    input wire d_i,
    output wire q_o
);
    reg s1_q;
    reg s2_q;
    reg s3_q;
    reg out_q;
    // first stage feeds only the second; change taken when 2 and 3 agree
    always @(posedge mclk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
            out_q <= 1'b0;
        end
        else
        begin
            s1_q <= d_i;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (s2_q == s3_q)
                out_q <= s3_q;
        end
    end
    assign q_o = out_q;
endmodule // losc_sync
`default_nettype wire

// ===== losc_combiner.v
// two-channel loss-of-signal status combiner
// overview
// each channel owns one six-bit enable set and one combined status pin.
// bit 0 routes the low-amplitude detector, bits 1 to 5 route the optional
// conditions: lost channel sync, pll unlock (either pll), decode error
// (invalid code or disparity), gain loop unlocked, offset cal not complete.
// all enables come up cleared, so nothing reaches a pin until software
// loads a set through en_load_i; both sets load together on that strobe.
//
// timing
// same-domain conditions reach the pin one edge after they are sampled.
// the amplitude detector is analog and free running, so it crosses three
// flops and an agreement filter first: about four to five edges in all.
// a single-cycle amplitude glitch is filtered away on purpose; a short
// drop-out of the analog detect should not flicker the status pin.
//
// structure
// every condition is masked by its own enable before the OR, so a fault
// on a disabled input can never leak into the pin through a shared term.
// the masked terms are kept as separate wires to make each rule traceable
// in a waveform; the tool folds them into one gate level anyway.
// the combined value is registered once, which keeps the pin glitch free
// while raw conditions settle; the readback port is the same flop, so the
// pin and the status readback can never disagree.
//
// limitations
// conditions other than amplitude are assumed to come from logic on this
// clock; a caller that feeds them from another clock must sync them first.
// the lock and calibration flags are active high "good" inputs, inverted
// here; tie them high on a channel that lacks those circuits.
//
`timescale 1ns/1ps
`default_nettype none
`include "losc_defs.vh"
module losc_combiner
(
    input wire mclk_i,
    input wire resetn_i,
    input wire [`LOSC_EN_W-1:0] en_a_i,
    input wire [`LOSC_EN_W-1:0] en_b_i,
    input wire en_load_i,
    input wire amp_low_a_i,
    input wire amp_low_b_i,
    input wire sync_lost_a_i,
    input wire sync_lost_b_i,
    input wire ls_pll_unlock_a_i,
    input wire ls_pll_unlock_b_i,
    input wire hs_pll_unlock_a_i,
    input wire hs_pll_unlock_b_i,
    input wire code_err_a_i,
    input wire code_err_b_i,
    input wire disp_err_a_i,
    input wire disp_err_b_i,
    input wire gain_loop_locked_a_i,
    input wire gain_loop_locked_b_i,
    input wire offset_cal_complete_a_i,
    input wire offset_cal_complete_b_i,
    output wire [`LOSC_EN_W-1:0] en_a_o,
    output wire [`LOSC_EN_W-1:0] en_b_o,
    output wire stat_a_o,
    output wire stat_b_o,
    output wire signal_lost_chan_a_o,
    output wire signal_lost_chan_b_o
);
    reg [`LOSC_EN_W-1:0] en_a_q;
    reg [`LOSC_EN_W-1:0] en_b_q;
    reg los_a_q;
    reg los_b_q;
    wire amp_a;
    wire amp_b;
    wire [`LOSC_EN_W-1:0] cond_a;
    wire [`LOSC_EN_W-1:0] cond_b;

    // analog detector outputs are asynchronous to the core clock
    losc_sync u_amp_a
    (
        .mclk_i(mclk_i),
        .resetn_i(resetn_i),
        .d_i(amp_low_a_i),
        .q_o(amp_a)
    );
    losc_sync u_amp_b
    (
        .mclk_i(mclk_i),
        .resetn_i(resetn_i),
        .d_i(amp_low_b_i),
        .q_o(amp_b)
    );

    // enable sets load together; all clear after reset
    always @(posedge mclk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            en_a_q <= `LOSC_EN_RST;
            en_b_q <= `LOSC_EN_RST;
        end
        else if (en_load_i)
        begin
            en_a_q <= en_a_i;
            en_b_q <= en_b_i;
        end
    end

    // raw conditions per channel; lock and calibration flags are inverted
    assign cond_a[`LOSC_EN_BASE] = amp_a;
    assign cond_a[`LOSC_EN_SYNC] = sync_lost_a_i;
    assign cond_a[`LOSC_EN_PLL] = ls_pll_unlock_a_i | hs_pll_unlock_a_i;
    assign cond_a[`LOSC_EN_DEC] = code_err_a_i | disp_err_a_i;
    assign cond_a[`LOSC_EN_GAIN] = ~gain_loop_locked_a_i;
    assign cond_a[`LOSC_EN_CAL] = ~offset_cal_complete_a_i;
    assign cond_b[`LOSC_EN_BASE] = amp_b;
    assign cond_b[`LOSC_EN_SYNC] = sync_lost_b_i;
    assign cond_b[`LOSC_EN_PLL] = ls_pll_unlock_b_i | hs_pll_unlock_b_i;
    assign cond_b[`LOSC_EN_DEC] = code_err_b_i | disp_err_b_i;
    assign cond_b[`LOSC_EN_GAIN] = ~gain_loop_locked_b_i;
    assign cond_b[`LOSC_EN_CAL] = ~offset_cal_complete_b_i;

    // channel a: each condition masked by its own enable bit
    // amplitude term, only seen after the synchroniser has agreed
    wire g_a_base;
    assign g_a_base = cond_a[`LOSC_EN_BASE] & en_a_q[`LOSC_EN_BASE];

    // lost channel sync term
    wire g_a_sync;
    assign g_a_sync = cond_a[`LOSC_EN_SYNC] & en_a_q[`LOSC_EN_SYNC];

    // either pll out of lock
    wire g_a_pll;
    assign g_a_pll = cond_a[`LOSC_EN_PLL] & en_a_q[`LOSC_EN_PLL];

    // invalid code or disparity error
    wire g_a_dec;
    assign g_a_dec = cond_a[`LOSC_EN_DEC] & en_a_q[`LOSC_EN_DEC];

    // gain loop not locked
    wire g_a_gain;
    assign g_a_gain = cond_a[`LOSC_EN_GAIN] & en_a_q[`LOSC_EN_GAIN];

    // offset calibration not complete
    wire g_a_cal;
    assign g_a_cal = cond_a[`LOSC_EN_CAL] & en_a_q[`LOSC_EN_CAL];

    // channel b: same terms from its own enables, never from channel a's
    // amplitude term
    wire g_b_base;
    assign g_b_base = cond_b[`LOSC_EN_BASE] & en_b_q[`LOSC_EN_BASE];

    // lost channel sync term
    wire g_b_sync;
    assign g_b_sync = cond_b[`LOSC_EN_SYNC] & en_b_q[`LOSC_EN_SYNC];

    // either pll out of lock
    wire g_b_pll;
    assign g_b_pll = cond_b[`LOSC_EN_PLL] & en_b_q[`LOSC_EN_PLL];

    // invalid code or disparity error
    wire g_b_dec;
    assign g_b_dec = cond_b[`LOSC_EN_DEC] & en_b_q[`LOSC_EN_DEC];

    // gain loop not locked
    wire g_b_gain;
    assign g_b_gain = cond_b[`LOSC_EN_GAIN] & en_b_q[`LOSC_EN_GAIN];

    // offset calibration not complete
    wire g_b_cal;
    assign g_b_cal = cond_b[`LOSC_EN_CAL] & en_b_q[`LOSC_EN_CAL];

    // next status per channel: any masked term raises it
    reg los_a_d;
    reg los_b_d;
    always @*
    begin
        los_a_d = g_a_base | g_a_sync | g_a_pll;
        los_a_d = los_a_d | g_a_dec | g_a_gain | g_a_cal;
        los_b_d = g_b_base | g_b_sync | g_b_pll;
        los_b_d = los_b_d | g_b_dec | g_b_gain | g_b_cal;
    end

    // registered to keep the pin glitch free, at the price of one cycle
    // of latency
    always @(posedge mclk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            los_a_q <= 1'b0;
            los_b_q <= 1'b0;
        end
        else
        begin
            los_a_q <= los_a_d;
            los_b_q <= los_b_d;
        end
    end

    assign signal_lost_chan_a_o = los_a_q;
    assign signal_lost_chan_b_o = los_b_q;
    // readback copies of the pin state and the enables
    assign stat_a_o = los_a_q;
    assign stat_b_o = los_b_q;
    assign en_a_o = en_a_q;
    assign en_b_o = en_b_q;
endmodule // losc_combiner
`default_nettype wire

// ===== losc_host.sv
// host model sampling the two status pins
`timescale 1ns/1ps
`default_nettype none
module losc_host
(
    input wire logic mclk_i,
    input wire logic [1:0] pin_i,
    output logic [1:0] seen_o
);
    // pins are plain levels to the host: one flop, no filtering
    always @(posedge mclk_i) seen_o <= pin_i;
endmodule // losc_host
`default_nettype wire

// ===== losc_monitor.sv
// assertion checker for the status combiner
`timescale 1ns/1ps
`default_nettype none
module losc_monitor
(
    input wire logic mclk_i, resetn_i, amp_low_a_i, sync_lost_a_i,
    input wire logic ls_pll_unlock_a_i, hs_pll_unlock_a_i, code_err_a_i,
    input wire logic disp_err_a_i, gain_loop_locked_a_i, stat_a_o,
    input wire logic offset_cal_complete_a_i, signal_lost_chan_a_o,
    input wire logic signal_lost_chan_b_o,
    input wire logic [5:0] en_a_o, en_b_o
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!resetn_i);
    wire st = signal_lost_chan_a_o;
    // status is registered: cause at one edge, pin high at the next
    property p_sy; en_a_o[1] && sync_lost_a_i |=> st; endproperty
    a_sy: assert property (p_sy) else $error("sync");
    property p_pl; en_a_o[2] && (ls_pll_unlock_a_i || hs_pll_unlock_a_i)
        |=> st; endproperty
    a_pl: assert property (p_pl) else $error("pll");
    property p_de; en_a_o[3] && (code_err_a_i || disp_err_a_i) |=> st;
    endproperty
    a_de: assert property (p_de) else $error("decode");
    property p_ga; en_a_o[4] && !gain_loop_locked_a_i |=> st; endproperty
    a_ga: assert property (p_ga) else $error("gain");
    property p_ca; en_a_o[5] && !offset_cal_complete_a_i |=> st; endproperty
    a_ca: assert property (p_ca) else $error("cal");
    // the amplitude pin is synchronised, so it must hold a few edges
    property p_am; (en_a_o[0] && amp_low_a_i)[*6] |=> st; endproperty
    a_am: assert property (p_am) else $error("amp");
    property p_of; en_b_o == 6'h00 |=> !signal_lost_chan_b_o; endproperty
    a_of: assert property (p_of) else $error("off");
    property p_rd; stat_a_o == st; endproperty
    a_rd: assert property (p_rd) else $error("readback");
    // main scenarios
    c_am: cover property (en_a_o[0] && st);
    c_ga: cover property (en_a_o[4] && st);
    c_b: cover property (signal_lost_chan_b_o);
endmodule // losc_monitor
bind losc_combiner losc_monitor i_losc_monitor (.*);
`default_nettype wire

// ===== tb_losc_combiner.sv
// self-checking bench for the status combiner
`timescale 1ns/1ps
`default_nettype none
module tb_losc_combiner;
    logic mclk_i = 0, resetn_i = 0, en_load_i = 0;
    logic [5:0] en_a_i = 0, en_b_i = 0, en_a_o, en_b_o;
    logic stat_a_o, stat_b_o, signal_lost_chan_a_o, signal_lost_chan_b_o;
    logic [7:0] c = 8'h3f; // 0 amp 1 sync 2-3 pll 4-5 dec 6 gain 7 cal
    logic [1:0] seen;
    int failures = 0, n_compared = 0;
    wire [5:0] st = {signal_lost_chan_a_o, signal_lost_chan_b_o, stat_a_o,
        stat_b_o, seen};
    always #5 mclk_i = ~mclk_i;
    // both channels share one fault word; only the enables tell them apart
    losc_combiner i_losc_combiner (.*, .amp_low_a_i(c[0]), .amp_low_b_i(c[0]),
        .sync_lost_a_i(c[1]), .sync_lost_b_i(c[1]), .ls_pll_unlock_a_i(c[2]),
        .ls_pll_unlock_b_i(c[2]), .hs_pll_unlock_a_i(c[3]),
        .hs_pll_unlock_b_i(c[3]), .code_err_a_i(c[4]), .code_err_b_i(c[4]),
        .disp_err_a_i(c[5]), .disp_err_b_i(c[5]),
        .gain_loop_locked_a_i(c[6]), .gain_loop_locked_b_i(c[6]),
        .offset_cal_complete_a_i(c[7]), .offset_cal_complete_b_i(c[7]));
    losc_host i_losc_host (.mclk_i, .pin_i(st[5:4]), .seen_o(seen));
    task chk(input string n, input logic [5:0] e, s);
        n_compared++;
        if (s !== e)
        begin
            failures++;
            $display("MISMATCH %s exp %h got %h", n, e, s);
        end
    endtask
    // one load strobe, then room for the slow amplitude path
    task ld(input logic [5:0] a, b);
        {en_a_i, en_b_i, en_load_i} = {a, b, 1'b1};
        @(negedge mclk_i);
        en_load_i = 0;
        repeat (6) @(negedge mclk_i);
        chk("en_a", a, en_a_o);
        chk("en_b", b, en_b_o);
    endtask
    // every path enabled with every fault, then a mid-run reset clears all
    task t_mid;
        c = 8'h3f;
        ld(6'h3f, 6'h3f);
        chk("pins", 6'h3f, st);
        resetn_i = 0;
        repeat (4) @(negedge mclk_i);
        resetn_i = 1;
        repeat (8) @(negedge mclk_i);
        chk("en_b", 6'h00, en_b_o);
        chk("pins", 6'h00, st);
    endtask
    // every fault raised before any enable: nothing may reach the pins
    task t_rst;
        repeat (4) @(negedge mclk_i);
        resetn_i = 1;
        repeat (8) @(negedge mclk_i);
        chk("pins", 6'h00, st);
    endtask
    // one fault at a time, routed by its own enable bit only
    task t_each;
        int i, m;
        for (i = 0; i < 8; i++)
        begin
            m = i < 2 ? i : i < 4 ? 2 : i < 6 ? 3 : i - 2;
            c = 8'hc0 ^ (8'h01 << i);
            ld(6'h01 << m, ~(6'h01 << m));
            chk("pins", 6'h2a, st);
            ld(~(6'h01 << m), 6'h01 << m);
            chk("pins", 6'h15, st);
        end
    endtask
    task end_of_test;
        if (failures == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial
    begin
        t_rst;
        t_each;
        t_mid;
        end_of_test;
    end
endmodule // tb_losc_combiner
`default_nettype wire
